// >>> sodm_top.sv
// Dependency masks and assertion logic for sequenced outputs 4 and 5
// Function
// R1 - 0x20: out4 term2 undervoltage and watchdog mask
// R2 - 0x21: out4 term2 secondary and inputs 1-2
// R3 - 0x22: out4 term2 inputs 3-4, other outputs
// R4 - 0x23 bit1: out4 term2 on output 8
// R5 - 0x40 bit3: out4 asserts on manual reset
// R6 - 0x24/0x27: out5 undervoltage and watchdog masks
// R7 - 0x25/0x28: out5 secondary and inputs 1-2
// R8 - 0x26/0x29: out5 inputs 3-4, other outputs
// R9 - 0x2a bit0, 0x3b bit4: out5 on output 8
// R10 - 0x40 bit4: out5 asserts on manual reset
// R11 - Mask zero ignores, one depends on signal
// R12 - Output deasserts when either term is one
// R13 - Host clears bits absent on small variant
// R14 - Term one when all selected healthy; empty is one
`timescale 1ns/1ps
module sodm_top #(
  parameter logic EIGHT_OUT = 1'b1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [sodm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [sodm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [sodm_pkg::DATA_W-1:0] reg_rdata_o,
  // Monitored conditions, high is fault; manual reset input is active low
  input wire logic [sodm_pkg::DET_W-1:0] primary_uv_i,
  input wire logic [sodm_pkg::DET_W-1:0] secondary_i,
  input wire logic [sodm_pkg::WDG_W-1:0] watchdog_i,
  input wire logic [sodm_pkg::GPI_W-1:0] general_logic_input_i,
  input wire logic manual_reset_input_n_i,
  // Other sequenced outputs {8,7,6,3,2,1}, high is asserted
  input wire logic [sodm_pkg::OUT_W-1:0] other_out_i,
  input wire logic out4_prod1_ok_i,
  // Sequenced outputs, high is asserted
  output logic sequenced_output_4_o,
  output logic sequenced_output_5_o
);
  logic [7:0] o4p2_pri;
  logic [7:0] o4p2_sec;
  logic [7:0] o4p2_io;
  logic o4p2_o8;
  logic [7:0] o5p1_pri;
  logic [7:0] o5p1_sec;
  logic [7:0] o5p1_io;
  logic o5p1_o8;
  logic [7:0] o5p2_pri;
  logic [7:0] o5p2_sec;
  logic [7:0] o5p2_io;
  logic o5p2_o8;
  logic mr_en4;
  logic mr_en5;
  logic [sodm_pkg::DET_W-1:0] pri_s;
  logic [sodm_pkg::DET_W-1:0] sec_s;
  logic [sodm_pkg::WDG_W-1:0] wdg_s;
  logic [sodm_pkg::GPI_W-1:0] gpi_s;
  logic mr_n_s;
  logic mr_low;
  logic [7:0] f_pri;
  logic [7:0] f_sec;
  logic [7:0] f_io4;
  logic [7:0] f_io5;
  logic [7:0] next_rdata;
  logic next_out4;
  logic next_out5;

  sodm_term_if t4b ();
  sodm_term_if t5a ();
  sodm_term_if t5b ();

  // Monitored pins cross into the clock domain
  sodm_sync #(.W(sodm_pkg::DET_W)) u_sync_pri (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i(primary_uv_i),
    .q_o(pri_s)
  );
  sodm_sync #(.W(sodm_pkg::DET_W)) u_sync_sec (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i(secondary_i),
    .q_o(sec_s)
  );
  sodm_sync #(.W(sodm_pkg::WDG_W)) u_sync_wdg (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i(watchdog_i),
    .q_o(wdg_s)
  );
  sodm_sync #(.W(sodm_pkg::GPI_W)) u_sync_gpi (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i(general_logic_input_i),
    .q_o(gpi_s)
  );
  sodm_sync #(.W(1), .RST_VAL(sodm_pkg::RST_LEVEL_HI)) u_sync_mr (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i(manual_reset_input_n_i),
    .q_o(mr_n_s)
  );

  assign mr_low = ~mr_n_s;

  // R1 out4 undervoltage and watchdog mask
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o4p2_pri <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_PRI) begin
      o4p2_pri <= reg_wdata_i;
    end
  end

  // R2 out4 secondary mask
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o4p2_sec <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_SEC) begin
      o4p2_sec <= reg_wdata_i;
    end
  end

  // R3 out4 input and output mask
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o4p2_io <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_IO) begin
      o4p2_io <= reg_wdata_i;
    end
  end

  // R4 out4 dependency on output 8
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o4p2_o8 <= sodm_pkg::RST_BIT;
    end else if (reg_wr_i && reg_addr_i == sodm_pkg::A_O8_DEP_A) begin
      o4p2_o8 <= reg_wdata_i[sodm_pkg::B_O8_OF_O4] & EIGHT_OUT;
    end
  end

  // R6 out5 undervoltage and watchdog masks
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o5p1_pri <= sodm_pkg::RST_MASK;
      o5p2_pri <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i) begin
      if (reg_addr_i == sodm_pkg::A_O5P1_PRI) begin
        o5p1_pri <= reg_wdata_i;
      end
      if (reg_addr_i == sodm_pkg::A_O5P2_PRI) begin
        o5p2_pri <= reg_wdata_i;
      end
    end
  end

  // R7 out5 secondary masks
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o5p1_sec <= sodm_pkg::RST_MASK;
      o5p2_sec <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i) begin
      if (reg_addr_i == sodm_pkg::A_O5P1_SEC) begin
        o5p1_sec <= reg_wdata_i;
      end
      if (reg_addr_i == sodm_pkg::A_O5P2_SEC) begin
        o5p2_sec <= reg_wdata_i;
      end
    end
  end

  // R8 out5 input and output masks
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o5p1_io <= sodm_pkg::RST_MASK;
      o5p2_io <= sodm_pkg::RST_MASK;
    end else if (reg_wr_i) begin
      if (reg_addr_i == sodm_pkg::A_O5P1_IO) begin
        o5p1_io <= reg_wdata_i;
      end
      if (reg_addr_i == sodm_pkg::A_O5P2_IO) begin
        o5p2_io <= reg_wdata_i;
      end
    end
  end

  // R9 out5 dependency on output 8
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      o5p1_o8 <= sodm_pkg::RST_BIT;
      o5p2_o8 <= sodm_pkg::RST_BIT;
    end else if (reg_wr_i) begin
      if (reg_addr_i == sodm_pkg::A_O8_DEP_B) begin
        o5p1_o8 <= reg_wdata_i[sodm_pkg::B_O8_OF_O5_P1] & EIGHT_OUT;
      end
      if (reg_addr_i == sodm_pkg::A_O8_DEP_C) begin
        o5p2_o8 <= reg_wdata_i[sodm_pkg::B_O8_OF_O5_P2] & EIGHT_OUT;
      end
    end
  end

  // R5 manual reset enables
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mr_en4 <= sodm_pkg::RST_BIT;
      mr_en5 <= sodm_pkg::RST_BIT;
    end else if (reg_wr_i && reg_addr_i == sodm_pkg::A_MR_EN) begin
      mr_en4 <= reg_wdata_i[sodm_pkg::B_MR_O4];
      mr_en5 <= reg_wdata_i[sodm_pkg::B_MR_O5];
    end
  end

  // Read back; bits owned by other outputs read as zero
  always_comb begin
    next_rdata = sodm_pkg::RD_NONE;
    unique case (reg_addr_i)
      sodm_pkg::A_O4P2_PRI: next_rdata = o4p2_pri;
      sodm_pkg::A_O4P2_SEC: next_rdata = o4p2_sec;
      sodm_pkg::A_O4P2_IO: next_rdata = o4p2_io;
      sodm_pkg::A_O8_DEP_A: next_rdata[sodm_pkg::B_O8_OF_O4] = o4p2_o8;
      sodm_pkg::A_O5P1_PRI: next_rdata = o5p1_pri;
      sodm_pkg::A_O5P1_SEC: next_rdata = o5p1_sec;
      sodm_pkg::A_O5P1_IO: next_rdata = o5p1_io;
      sodm_pkg::A_O5P2_PRI: next_rdata = o5p2_pri;
      sodm_pkg::A_O5P2_SEC: next_rdata = o5p2_sec;
      sodm_pkg::A_O5P2_IO: next_rdata = o5p2_io;
      sodm_pkg::A_O8_DEP_B: next_rdata[sodm_pkg::B_O8_OF_O5_P1] = o5p1_o8;
      sodm_pkg::A_O8_DEP_C: next_rdata[sodm_pkg::B_O8_OF_O5_P2] = o5p2_o8;
      sodm_pkg::A_MR_EN: begin
        next_rdata[sodm_pkg::B_MR_O4] = mr_en4;
        next_rdata[sodm_pkg::B_MR_O5] = mr_en5;
      end
      default: next_rdata = sodm_pkg::RD_NONE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= sodm_pkg::RD_NONE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Fault vectors in mask bit order
  assign f_pri = {wdg_s, pri_s};
  assign f_sec = {gpi_s[1:0], sec_s};
  // Out4 sees outputs 1,2,3,5,6,7; out5 sees 1,2,3,4,6,7
  assign f_io4 = {other_out_i[4:3], sequenced_output_5_o,
                  other_out_i[2:0], gpi_s[3:2]};
  assign f_io5 = {other_out_i[4:3], sequenced_output_4_o,
                  other_out_i[2:0], gpi_s[3:2]};

  // R11 masks select the monitored signals
  assign t4b.mask = sodm_pkg::dep_vec(o4p2_pri, o4p2_sec, o4p2_io, o4p2_o8);
  assign t4b.fault = sodm_pkg::dep_vec(f_pri, f_sec, f_io4, other_out_i[5]);
  assign t5a.mask = sodm_pkg::dep_vec(o5p1_pri, o5p1_sec, o5p1_io, o5p1_o8);
  assign t5a.fault = sodm_pkg::dep_vec(f_pri, f_sec, f_io5, other_out_i[5]);
  assign t5b.mask = sodm_pkg::dep_vec(o5p2_pri, o5p2_sec, o5p2_io, o5p2_o8);
  assign t5b.fault = t5a.fault;

  sodm_term u_t4b (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .t(t4b.term)
  );
  sodm_term u_t5a (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .t(t5a.term)
  );
  sodm_term u_t5b (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .t(t5b.term)
  );

  // R12 either term releases; R5 and R10 manual reset wins
  assign next_out4 = (mr_en4 & mr_low) | ~(out4_prod1_ok_i | t4b.ok);
  assign next_out5 = (mr_en5 & mr_low) | ~(t5a.ok | t5b.ok);

  // Outputs start asserted so supplies stay held through reset
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sequenced_output_4_o <= sodm_pkg::RST_LEVEL_HI;
      sequenced_output_5_o <= sodm_pkg::RST_LEVEL_HI;
    end else begin
      sequenced_output_4_o <= next_out4;
      sequenced_output_5_o <= next_out5;
    end
  end

  AST_O4P2_PRI_WR: assert property ( // R1
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_PRI)
      |=> o4p2_pri == $past(reg_wdata_i))
    else $error("0x20 write not stored");

  AST_O4P2_SEC_WR: assert property ( // R2
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_SEC)
      |=> ##1 t4b.mask[15:8] == $past(reg_wdata_i, 2))
    else $error("0x21 write not in term mask");

  AST_O4P2_IO_RD: assert property ( // R3
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_IO) ##1 !reg_wr_i ##1
    (reg_rd_i && !reg_wr_i && reg_addr_i == sodm_pkg::A_O4P2_IO)
      |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("0x22 read back wrong");

  AST_O4_O8_SEL: assert property ( // R4
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O8_DEP_A)
      |=> o4p2_o8 == ($past(reg_wdata_i[1]) && EIGHT_OUT))
    else $error("0x23 bit 1 not applied");

  AST_O4_MR_ASSERT: assert property ( // R5
    @(posedge mclk_i) disable iff (!reset_n_i)
    (mr_en4 && mr_low) |=> sequenced_output_4_o)
    else $error("output 4 not asserted on manual reset");

  AST_O5_PRI_WR: assert property ( // R6
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O5P2_PRI)
      |=> o5p2_pri == $past(reg_wdata_i) && $stable(o5p1_pri))
    else $error("0x27 write wrong");

  AST_O5_SEC_WR: assert property ( // R7
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O5P1_SEC)
      |=> o5p1_sec == $past(reg_wdata_i) && $stable(o5p2_sec))
    else $error("0x25 write wrong");

  AST_O5_IO_WR: assert property ( // R8
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O5P2_IO)
      |=> o5p2_io == $past(reg_wdata_i))
    else $error("0x29 write wrong");

  AST_O5_O8_SEL: assert property ( // R9
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == sodm_pkg::A_O8_DEP_C)
      |=> o5p2_o8 == ($past(reg_wdata_i[4]) && EIGHT_OUT))
    else $error("0x3b bit 4 not applied");

  AST_O5_MR_ASSERT: assert property ( // R10
    @(posedge mclk_i) disable iff (!reset_n_i)
    (mr_en5 && mr_low) |=> sequenced_output_5_o)
    else $error("output 5 not asserted on manual reset");

  AST_O5_RELEASE: assert property ( // R12
    @(posedge mclk_i) disable iff (!reset_n_i)
    (!(mr_en5 && mr_low) && (t5a.ok || t5b.ok))
      |=> !sequenced_output_5_o)
    else $error("output 5 held with a term at one");

  AST_O4_HOLD: assert property ( // R12
    @(posedge mclk_i) disable iff (!reset_n_i)
    (!out4_prod1_ok_i && !t4b.ok) |=> sequenced_output_4_o)
    else $error("output 4 released with both terms zero");

  AST_EMPTY_TERM: assert property ( // R14
    @(posedge mclk_i) disable iff (!reset_n_i)
    (t5a.mask == '0) [*2] |-> t5a.ok)
    else $error("empty term not one");
endmodule

// >>> sodm_pkg.sv
// Shared constants and helpers for the output dependency block
package sodm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEP_W = 25;
  localparam int OUT_W = 6;
  localparam int DET_W = 6;
  localparam int GPI_W = 4;
  localparam int WDG_W = 2;
  // Register offsets
  localparam logic [7:0] A_O4P2_PRI = 8'h20;
  localparam logic [7:0] A_O4P2_SEC = 8'h21;
  localparam logic [7:0] A_O4P2_IO = 8'h22;
  localparam logic [7:0] A_O8_DEP_A = 8'h23;
  localparam logic [7:0] A_O5P1_PRI = 8'h24;
  localparam logic [7:0] A_O5P1_SEC = 8'h25;
  localparam logic [7:0] A_O5P1_IO = 8'h26;
  localparam logic [7:0] A_O5P2_PRI = 8'h27;
  localparam logic [7:0] A_O5P2_SEC = 8'h28;
  localparam logic [7:0] A_O5P2_IO = 8'h29;
  localparam logic [7:0] A_O8_DEP_B = 8'h2a;
  localparam logic [7:0] A_O8_DEP_C = 8'h3b;
  localparam logic [7:0] A_MR_EN = 8'h40;
  // Reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic RST_LEVEL_HI = 1'b1;
  localparam logic [7:0] RD_NONE = 8'h00;
  // Bit positions inside shared registers
  localparam int B_O8_OF_O4 = 1;
  localparam int B_O8_OF_O5_P1 = 0;
  localparam int B_O8_OF_O5_P2 = 4;
  localparam int B_MR_O4 = 3;
  localparam int B_MR_O5 = 4;
  // Product term AND over selected non-fault signals
  function automatic logic term_ok(input logic [DEP_W-1:0] mask,
                                   input logic [DEP_W-1:0] fault);
    return &(~mask | ~fault);
  endfunction
  // Packs three mask bytes and the output 8 bit in vector order
  function automatic logic [DEP_W-1:0] dep_vec(input logic [7:0] pri,
                                               input logic [7:0] sec,
                                               input logic [7:0] io,
                                               input logic o8);
    return {o8, io, sec, pri};
  endfunction
endpackage

// >>> sodm_term_if.sv
// Mask, fault vector and result of one product term
`timescale 1ns/1ps
interface sodm_term_if;
  logic [sodm_pkg::DEP_W-1:0] mask;
  logic [sodm_pkg::DEP_W-1:0] fault;
  logic ok;
  modport src (output mask, output fault, input ok);
  modport term (input mask, input fault, output ok);
endinterface

// >>> sodm_sync.sv
// Two-flop synchroniser for monitored levels
`timescale 1ns/1ps
module sodm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// >>> sodm_term.sv
// Registered product term evaluator
`timescale 1ns/1ps
module sodm_term (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Term
  sodm_term_if.term t
);
  // R14 all selected healthy
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      t.ok <= sodm_pkg::RST_BIT;
    end else begin
      t.ok <= sodm_pkg::term_ok(t.mask, t.fault);
    end
  end

  AST_TERM_FAULT_BLOCKS: assert property ( // R11
    @(posedge mclk_i) disable iff (!reset_n_i)
    ((t.mask & t.fault) != '0) |=> !t.ok)
    else $error("selected fault did not clear the term");

  AST_TERM_HEALTHY_PASSES: assert property ( // R14
    @(posedge mclk_i) disable iff (!reset_n_i)
    ((t.mask & t.fault) == '0) |=> t.ok)
    else $error("healthy or empty term did not evaluate to one");
endmodule

// >>> sodm_peer.sv
// Model of the neighbouring sequencer logic that feeds output states
`timescale 1ns/1ps
module sodm_peer (
  // Clock
  input wire logic mclk_i,
  // Commanded levels
  input wire logic [5:0] other_cmd_i,
  input wire logic prod1_cmd_i,
  // Levels seen by the block
  output logic [5:0] other_out_o,
  output logic prod1_ok_o
);
  // Neighbouring outputs are registered on the shared clock
  always_ff @(posedge mclk_i) begin
    other_out_o <= other_cmd_i;
    prod1_ok_o <= prod1_cmd_i;
  end
endmodule

// >>> sequencer_output_dependency_masks_test.sv
// Self-checking bench for the output dependency block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end \
end
module sequencer_output_dependency_masks_test;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  // Fault levels {out8,7,6,3,2,1, general_logic_input_4..1, sec6..1, wdg2,1, pri6..1}
  logic [23:0] pf = 24'h000000;
  logic mr_n = 1'b1;
  logic p1 = 1'b0;
  logic [5:0] oo;
  logic p1q;
  logic o4;
  logic o5;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #20 mclk_i = ~mclk_i;

  sodm_peer PEER (
    .mclk_i(mclk_i),
    .other_cmd_i(pf[23:18]),
    .prod1_cmd_i(p1),
    .other_out_o(oo),
    .prod1_ok_o(p1q)
  );

  sodm_top DUT (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .primary_uv_i(pf[5:0]),
    .secondary_i(pf[13:8]),
    .watchdog_i(pf[7:6]),
    .general_logic_input_i(pf[17:14]),
    .manual_reset_input_n_i(mr_n),
    .other_out_i(oo),
    .out4_prod1_ok_i(p1q),
    .sequenced_output_4_o(o4),
    .sequenced_output_5_o(o5)
  );

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    rd = 1'b1;
    @(negedge mclk_i);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic settle();
    repeat (6) @(negedge mclk_i);
  endtask

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_regs();
    logic [7:0] a[13] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
                          8'h27, 8'h28, 8'h29, 8'h2a, 8'h3b, 8'h40};
    logic [7:0] m[13] = '{8'hff, 8'hff, 8'hff, 8'h02, 8'hff, 8'hff, 8'hff,
                          8'hff, 8'hff, 8'hff, 8'h01, 8'h10, 8'h18};
    logic [7:0] d;
    for (int k = 0; k < 13; k++) begin
      rd_reg(a[k], d);
      `CHK(d, 8'h00)
      wr_reg(a[k], 8'hff);
      rd_reg(a[k], d);
      `CHK(d, m[k])
      wr_reg(a[k], 8'h00);
    end
    wr_reg(8'h30, 8'hff);
    rd_reg(8'h30, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_empty();
    settle();
    `CHK(o4, 1'b0)
    `CHK(o5, 1'b0)
  endtask

  task automatic t_latency();
    wr_reg(8'h24, 8'h01);
    wr_reg(8'h27, 8'h01);
    settle();
    pf = 24'h000001;
    repeat (3) @(negedge mclk_i);
    `CHK(o5, 1'b0)
    @(negedge mclk_i);
    `CHK(o5, 1'b1)
    pf = 24'h000000;
    wr_reg(8'h24, 8'h00);
    wr_reg(8'h27, 8'h00);
  endtask

  task automatic t_either();
    wr_reg(8'h20, 8'h01);
    pf = 24'h000001;
    p1 = 1'b1;
    settle();
    `CHK(o4, 1'b0)
    p1 = 1'b0;
    settle();
    `CHK(o4, 1'b1)
    pf = 24'h000000;
    settle();
    `CHK(o4, 1'b0)
    wr_reg(8'h20, 8'h00);
  endtask

  // Walk one selected bit per term; the other term is held false except for out5 while output 8 is clear
  task automatic dep(input int w);
    logic [7:0] b;
    logic [7:0] oa;
    int sh;
    int p;
    logic [24:0] v;
    logic x;
    b = (w == 0) ? 8'h20 : (w == 1) ? 8'h24 : 8'h27;
    oa = (w == 0) ? 8'h23 : (w == 1) ? 8'h2a : 8'h3b;
    sh = (w == 0) ? 1 : (w == 1) ? 0 : 4;
    if (w == 1) wr_reg(8'h3b, 8'h10);
    if (w == 2) wr_reg(8'h2a, 8'h01);
    for (int i = 0; i < 25; i++) begin
      if (i != 21) begin
        v = 25'd1 << i;
        p = (i < 21) ? i : i - 1;
        wr_reg(b, v[7:0]);
        wr_reg(b + 8'h01, v[15:8]);
        wr_reg(b + 8'h02, v[23:16]);
        wr_reg(oa, {7'h00, v[24]} << sh);
        pf = ~(24'd1 << p);
        settle();
        x = (w == 0) ? o4 : o5;
        `CHK(x, 1'b0)
        pf = (24'd1 << p) | 24'h800000;
        settle();
        x = (w == 0) ? o4 : o5;
        `CHK(x, 1'b1)
      end
    end
    for (int k = 0; k < 3; k++) wr_reg(b + 8'(k), 8'h00);
    wr_reg(oa, 8'h00);
    wr_reg(8'h3b, 8'h00);
    wr_reg(8'h2a, 8'h00);
    pf = 24'h000000;
  endtask

  task automatic t_mr();
    wr_reg(8'h26, 8'h20);
    wr_reg(8'h3b, 8'h10);
    pf = 24'h800000;
    p1 = 1'b1;
    wr_reg(8'h40, 8'h08);
    settle();
    `CHK(o4, 1'b0)
    `CHK(o5, 1'b0)
    mr_n = 1'b0;
    settle();
    `CHK(o4, 1'b1)
    `CHK(o5, 1'b1)
    mr_n = 1'b1;
    settle();
    `CHK(o4, 1'b0)
    `CHK(o5, 1'b0)
    wr_reg(8'h26, 8'h00);
    wr_reg(8'h40, 8'h10);
    mr_n = 1'b0;
    settle();
    `CHK(o5, 1'b1)
    `CHK(o4, 1'b0)
    wr_reg(8'h40, 8'h00);
    settle();
    `CHK(o5, 1'b0)
    mr_n = 1'b1;
    p1 = 1'b0;
    pf = 24'h000000;
    wr_reg(8'h3b, 8'h00);
  endtask

  initial begin
    repeat (8) @(negedge mclk_i);
    reset_n_i = 1'b1;
    // full part, every mask bit legal
    t_regs();
    t_empty();
    t_latency();
    t_either();
    dep(0);
    dep(1);
    dep(2);
    t_mr();
    give_verdict();
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (10000) @(posedge mclk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule
